// ===== core/dpg_regs.vh
// Purpose: Constants of the dual GPIO port block
// Assumes: Byte-wide register port, one register per address
// Notes:   Included by bare name from every design file that uses its constants
`ifndef DPG_REGS_VH
`define DPG_REGS_VH

// Bus and port widths
`define DPG_ADDR_W        4
`define DPG_DATA_W        8
`define DPG_PORT_W        8

// Register addresses
`define DPG_ADDR_P1_DIR   4'h0
`define DPG_ADDR_P1_LATCH 4'h1
`define DPG_ADDR_P1_PULL  4'h2
`define DPG_ADDR_P2_DIR   4'h3
`define DPG_ADDR_P2_LATCH 4'h4
`define DPG_ADDR_P2_PULL  4'h5

// Reset values
`define DPG_RST_DIR       8'h00
`define DPG_RST_LATCH     8'h00
`define DPG_RST_PULL      8'h00

// Read answers with no stored state behind them
`define DPG_RD_WO         8'h00
`define DPG_RD_UNMAPPED   8'h00
`define DPG_RD_IDLE       8'h00

`endif

// ===== core/dpg_sync.v
// Purpose: Two-stage synchroniser for a bus of pin levels
// Assumes: Bits are independent levels; no word coherence needed
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`include "dpg_regs.vh"

module dpg_sync
(
   input  wire                   sys_clk,
   input  wire                   rstn,
   input  wire [`DPG_PORT_W-1:0] async_in,
   output reg  [`DPG_PORT_W-1:0] sync_out
);

   reg [`DPG_PORT_W-1:0] meta_q;

   // Two flops, both cleared by reset
   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         meta_q   <= `DPG_RST_LATCH;
         sync_out <= `DPG_RST_LATCH;
      end
      else
      begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule

// ===== core/dpg_pin_drv.v
// Purpose: Registered pin driver and pull-up control for one 8-bit port
// Assumes: All control inputs come from logic on sys_clk
// Notes:   Alternate function inputs are tied low where a port has none
`timescale 1ns/1ps
`include "dpg_regs.vh"

module dpg_pin_drv
(
   input  wire                   sys_clk,
   input  wire                   rstn,
   input  wire [`DPG_PORT_W-1:0] dir,
   input  wire [`DPG_PORT_W-1:0] latch,
   input  wire [`DPG_PORT_W-1:0] pull_ctl,
   input  wire [`DPG_PORT_W-1:0] alt_en,
   input  wire [`DPG_PORT_W-1:0] alt_val,
   input  wire                   pull_block,
   output reg  [`DPG_PORT_W-1:0] pin_out,
   output reg  [`DPG_PORT_W-1:0] pin_oe,
   output reg  [`DPG_PORT_W-1:0] pull_en
);

   // Per bit: alternate value wherever alternate is enabled, latch otherwise
   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pin_out <= `DPG_RST_LATCH;
         pin_oe  <= `DPG_RST_DIR;
         pull_en <= `DPG_RST_PULL;
      end
      else
      begin
         pin_oe  <= dir;
         pin_out <= (alt_en & alt_val) | (~alt_en & latch);
         // Pull-up only on inputs, never while blocked by standby
         pull_en <= pull_block ? `DPG_RST_PULL : (~dir & pull_ctl);
      end
   end

endmodule

// ===== core/dpg_top.v
// Purpose: Two 8-bit general I/O ports with direction, latch and pull-up control
// Assumes: sys_clk at 50 MHz; register port and PWM inputs on sys_clk
// Notes:   Pin levels are synchronised before any read sees them
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
`include "dpg_regs.vh"

module dpg_top
(
   input  wire                   sys_clk,
   input  wire                   rstn,
   input  wire [`DPG_ADDR_W-1:0] reg_addr,
   input  wire [`DPG_DATA_W-1:0] reg_wdata,
   input  wire                   reg_wr,
   input  wire                   reg_rd,
   output reg  [`DPG_DATA_W-1:0] reg_rdata,
   input  wire                   hw_standby,
   input  wire [`DPG_PORT_W-1:0] pwm_outputs,
   input  wire [`DPG_PORT_W-1:0] pwm_channel_output_enable,
   input  wire [`DPG_PORT_W-1:0] first_port_pins_in,
   output wire [`DPG_PORT_W-1:0] first_port_pins_out,
   output wire [`DPG_PORT_W-1:0] first_port_pins_oe,
   output wire [`DPG_PORT_W-1:0] first_port_pullup_on,
   input  wire [`DPG_PORT_W-1:0] second_port_pins_in,
   output wire [`DPG_PORT_W-1:0] second_port_pins_out,
   output wire [`DPG_PORT_W-1:0] second_port_pins_oe,
   output wire [`DPG_PORT_W-1:0] second_port_pullup_on
);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations
   ////////////////////////////////////////////////////////////////////////////////

   // Software-visible state
   reg  [`DPG_PORT_W-1:0] port1_direction_q;
   reg  [`DPG_PORT_W-1:0] port1_output_latch_q;
   reg  [`DPG_PORT_W-1:0] port1_pullup_enable_q;
   reg  [`DPG_PORT_W-1:0] port2_direction_q;
   reg  [`DPG_PORT_W-1:0] port2_output_latch_q;
   reg  [`DPG_PORT_W-1:0] port2_pullup_enable_q;

   // Next values of the software-visible state
   reg  [`DPG_PORT_W-1:0] port1_direction_d;
   reg  [`DPG_PORT_W-1:0] port1_output_latch_d;
   reg  [`DPG_PORT_W-1:0] port1_pullup_enable_d;
   reg  [`DPG_PORT_W-1:0] port2_direction_d;
   reg  [`DPG_PORT_W-1:0] port2_output_latch_d;
   reg  [`DPG_PORT_W-1:0] port2_pullup_enable_d;

   // Read path
   reg  [`DPG_DATA_W-1:0] reg_rdata_d;

   // Standby register, so pull-up gating sees no pin-level glitches
   reg                    standby_meta_q;
   reg                    standby_q;

   // PWM takeover mask: output direction and channel enabled
   wire [`DPG_PORT_W-1:0] port1_pwm_sel;

   // Synchronised pin levels
   wire [`DPG_PORT_W-1:0] port1_pin_sync;
   wire [`DPG_PORT_W-1:0] port2_pin_sync;

   // Values software sees when reading a port
   wire [`DPG_PORT_W-1:0] port1_read_val;
   wire [`DPG_PORT_W-1:0] port2_read_val;

   ////////////////////////////////////////////////////////////////////////////////
   // Functions
   ////////////////////////////////////////////////////////////////////////////////

   // Port read: latch on output bits, pin level on input bits
   function [`DPG_PORT_W-1:0] dpg_port_read;
      input [`DPG_PORT_W-1:0] dir;
      input [`DPG_PORT_W-1:0] latch;
      input [`DPG_PORT_W-1:0] pin;
      begin
         dpg_port_read = (dir & latch) | (~dir & pin);
      end
   endfunction

   // Address match for a write strobe
   function dpg_wr_hit;
      input                   wr;
      input [`DPG_ADDR_W-1:0] addr;
      input [`DPG_ADDR_W-1:0] target;
      begin
         dpg_wr_hit = wr && (addr == target);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Pin level synchronisers
   ////////////////////////////////////////////////////////////////////////////////

   // First port pin levels
   dpg_sync u_sync_p1
   (
      .sys_clk  (sys_clk),
      .rstn     (rstn),
      .async_in (first_port_pins_in),
      .sync_out (port1_pin_sync)
   );

   // Second port pin levels
   dpg_sync u_sync_p2
   (
      .sys_clk  (sys_clk),
      .rstn     (rstn),
      .async_in (second_port_pins_in),
      .sync_out (port2_pin_sync)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Standby capture
   ////////////////////////////////////////////////////////////////////////////////

   // Standby comes from chip-level logic that may run off another source
   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         standby_meta_q <= 1'b0;
         standby_q      <= 1'b0;
      end
      else
      begin
         standby_meta_q <= hw_standby;
         standby_q      <= standby_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register writes
   ////////////////////////////////////////////////////////////////////////////////

   // First port next values
   always @*
   begin
      port1_direction_d     = port1_direction_q;
      port1_output_latch_d  = port1_output_latch_q;
      port1_pullup_enable_d = port1_pullup_enable_q;
      if (dpg_wr_hit(reg_wr, reg_addr, `DPG_ADDR_P1_DIR))
      begin
         port1_direction_d = reg_wdata;
      end
      // Latch written regardless of direction
      if (dpg_wr_hit(reg_wr, reg_addr, `DPG_ADDR_P1_LATCH))
      begin
         port1_output_latch_d = reg_wdata;
      end
      if (dpg_wr_hit(reg_wr, reg_addr, `DPG_ADDR_P1_PULL))
      begin
         port1_pullup_enable_d = reg_wdata;
      end
   end

   // Second port next values
   always @*
   begin
      port2_direction_d     = port2_direction_q;
      port2_output_latch_d  = port2_output_latch_q;
      port2_pullup_enable_d = port2_pullup_enable_q;
      if (dpg_wr_hit(reg_wr, reg_addr, `DPG_ADDR_P2_DIR))
      begin
         port2_direction_d = reg_wdata;
      end
      // Latch written regardless of direction
      if (dpg_wr_hit(reg_wr, reg_addr, `DPG_ADDR_P2_LATCH))
      begin
         port2_output_latch_d = reg_wdata;
      end
      if (dpg_wr_hit(reg_wr, reg_addr, `DPG_ADDR_P2_PULL))
      begin
         port2_pullup_enable_d = reg_wdata;
      end
   end

   // Port 1 direction; clears to input so no pad is driven out of reset
   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         port1_direction_q <= `DPG_RST_DIR;
      end
      else
      begin
         port1_direction_q <= port1_direction_d;
      end
   end

   // Port 1 output latch; kept whatever the direction, so no glitch on turn-around
   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         port1_output_latch_q <= `DPG_RST_LATCH;
      end
      else
      begin
         port1_output_latch_q <= port1_output_latch_d;
      end
   end

   // Port 1 pull-up control; direction and standby gating live in the driver
   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         port1_pullup_enable_q <= `DPG_RST_PULL;
      end
      else
      begin
         port1_pullup_enable_q <= port1_pullup_enable_d;
      end
   end

   // Port 2 direction; same input default as port 1
   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         port2_direction_q <= `DPG_RST_DIR;
      end
      else
      begin
         port2_direction_q <= port2_direction_d;
      end
   end

   // Port 2 output latch; written even while the pins are inputs
   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         port2_output_latch_q <= `DPG_RST_LATCH;
      end
      else
      begin
         port2_output_latch_q <= port2_output_latch_d;
      end
   end

   // Port 2 pull-up control; only the request, gating is downstream
   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         port2_pullup_enable_q <= `DPG_RST_PULL;
      end
      else
      begin
         port2_pullup_enable_q <= port2_pullup_enable_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register reads
   ////////////////////////////////////////////////////////////////////////////////

   // Port read values; pin side is two cycles behind the pads
   assign port1_read_val = dpg_port_read(port1_direction_q,
                                         port1_output_latch_q,
                                         port1_pin_sync);
   assign port2_read_val = dpg_port_read(port2_direction_q,
                                         port2_output_latch_q,
                                         port2_pin_sync);

   // Read mux; direction registers are write-only and read as zero
   always @*
   begin
      reg_rdata_d = `DPG_RD_IDLE;
      if (reg_rd)
      begin
         case (reg_addr)
            `DPG_ADDR_P1_DIR:   reg_rdata_d = `DPG_RD_WO;
            `DPG_ADDR_P1_LATCH: reg_rdata_d = port1_read_val;
            `DPG_ADDR_P1_PULL:  reg_rdata_d = port1_pullup_enable_q;
            `DPG_ADDR_P2_DIR:   reg_rdata_d = `DPG_RD_WO;
            `DPG_ADDR_P2_LATCH: reg_rdata_d = port2_read_val;
            `DPG_ADDR_P2_PULL:  reg_rdata_d = port2_pullup_enable_q;
            default:            reg_rdata_d = `DPG_RD_UNMAPPED;
         endcase
      end
   end

   // Read data stand for one cycle only, zero otherwise
   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         reg_rdata <= `DPG_RD_IDLE;
      end
      else
      begin
         reg_rdata <= reg_rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin drivers
   ////////////////////////////////////////////////////////////////////////////////

   // PWM takes a bit only when it is an output and its channel is enabled
   assign port1_pwm_sel = port1_direction_q & pwm_channel_output_enable;

   // First port: direction, latch or PWM, pull-up gated by standby
   dpg_pin_drv u_drv_p1
   (
      .sys_clk    (sys_clk),
      .rstn       (rstn),
      .dir        (port1_direction_q),
      .latch      (port1_output_latch_q),
      .pull_ctl   (port1_pullup_enable_q),
      .alt_en     (port1_pwm_sel),
      .alt_val    (pwm_outputs),
      .pull_block (standby_q),
      .pin_out    (first_port_pins_out),
      .pin_oe     (first_port_pins_oe),
      .pull_en    (first_port_pullup_on)
   );

   // Second port: no alternate function, same pull-up gating
   dpg_pin_drv u_drv_p2
   (
      .sys_clk    (sys_clk),
      .rstn       (rstn),
      .dir        (port2_direction_q),
      .latch      (port2_output_latch_q),
      .pull_ctl   (port2_pullup_enable_q),
      .alt_en     (`DPG_RST_DIR),
      .alt_val    (`DPG_RST_LATCH),
      .pull_block (standby_q),
      .pin_out    (second_port_pins_out),
      .pin_oe     (second_port_pins_oe),
      .pull_en    (second_port_pullup_on)
   );

endmodule

// ===== core/dpg_top_end.v
// Purpose: Time unit for design units compiled after the top
// Assumes: Holds no logic of its own
// Notes:   Nothing here turns into hardware
`timescale 1ns/1ps

// ===== testbench/dpg_sva.sv
// Purpose: Port-level assertions for the dual GPIO port block
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Pin outputs settle one edge after a register change
`timescale 1ns/1ps
`include "dpg_regs.vh"

module dpg_sva
(
   input wire       sys_clk,
   input wire       rstn,
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire       reg_wr,
   input wire       reg_rd,
   input wire [7:0] reg_rdata,
   input wire       hw_standby,
   input wire [7:0] pwm_outputs,
   input wire [7:0] pwm_channel_output_enable,
   input wire [7:0] first_port_pins_out,
   input wire [7:0] first_port_pins_oe,
   input wire [7:0] first_port_pullup_on,
   input wire [7:0] second_port_pins_out,
   input wire [7:0] second_port_pins_oe,
   input wire [7:0] second_port_pullup_on
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////////////////////////////////////////////
   // No writes and no PWM takeover, so latch and pins agree
   sequence quiet_s;
      (!reg_wr && pwm_channel_output_enable == 8'h00)[*3];
   endsequence
   sequence rd1_s;
      reg_rd && reg_addr == `DPG_ADDR_P1_LATCH;
   endsequence
   sequence rd2_s;
      reg_rd && reg_addr == `DPG_ADDR_P2_LATCH;
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   AST_P1_OE: assert property (reg_wr && reg_addr == `DPG_ADDR_P1_DIR
      |-> ##2 first_port_pins_oe == $past(reg_wdata, 2)) else $error("port 1 enable wrong");
   AST_P2_OE: assert property (reg_wr && reg_addr == `DPG_ADDR_P2_DIR
      |-> ##2 second_port_pins_oe == $past(reg_wdata, 2)) else $error("port 2 enable wrong");
   AST_P1_PULL: assert property ((first_port_pullup_on & first_port_pins_oe) == 8'h00)
      else $error("port 1 pull-up on an output");
   AST_P2_PULL: assert property ((second_port_pullup_on & second_port_pins_oe) == 8'h00)
      else $error("port 2 pull-up on an output");
   AST_STBY: assert property (hw_standby[*4]
      |-> (first_port_pullup_on | second_port_pullup_on) == 8'h00) else $error("standby pull-up");
   AST_P1_RD: assert property (quiet_s ##0 rd1_s
      |=> (reg_rdata & first_port_pins_oe) == (first_port_pins_out & first_port_pins_oe))
      else $error("port 1 output bits read wrong");
   AST_P2_RD: assert property (quiet_s ##0 rd2_s
      |=> (reg_rdata & second_port_pins_oe) == (second_port_pins_out & second_port_pins_oe))
      else $error("port 2 output bits read wrong");
   AST_PWM: assert property (1'b1 |=> ((first_port_pins_out ^ $past(pwm_outputs))
      & first_port_pins_oe & $past(pwm_channel_output_enable)) == 8'h00)
      else $error("pwm value not on pin");
endmodule

bind dpg_top dpg_sva u_sva (.sys_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .hw_standby, .pwm_outputs, .pwm_channel_output_enable, .first_port_pins_out,
   .first_port_pins_oe, .first_port_pullup_on, .second_port_pins_out, .second_port_pins_oe,
   .second_port_pullup_on);

// ===== testbench/dpg_board.sv
// Purpose: Board-side pad model for one 8-bit port
// Assumes: Pads settle within the cycle
// Notes:   Short mode inverts driven bits to prove reads ignore pads
`timescale 1ns/1ps

module dpg_board
(
   input  wire       sys_clk,
   input  wire [7:0] pin_out,
   input  wire [7:0] pin_oe,
   input  wire [7:0] pull_on,
   input  wire [7:0] ext_val,
   input  wire       ext_float,
   input  wire       fight,
   output wire [7:0] pin_in
);
   reg [7:0] noise_q = 8'h55;
   // Floating pad wanders so a stale level never passes as a read
   always @(posedge sys_clk)
      noise_q <= ~noise_q;
   // Resolve pad from chip drive, board drive and pull-up
   assign pin_in = (pin_oe & (fight ? ~pin_out : pin_out))
                 | (~pin_oe & (ext_float ? (pull_on | noise_q) : ext_val));
endmodule

// ===== testbench/test_dual_port_gpio_pullup.sv
// Purpose: Self-checking bench for the dual GPIO port block
// Assumes: Register port master drives right after the rising edge
// Notes:   Pad reads wait out the two-flop synchroniser
`timescale 1ns/1ps

module test_dual_port_gpio_pullup;
   reg        sys_clk = 1'b0;
   reg        rstn = 1'b0;
   reg  [3:0] reg_addr = 4'h0;
   reg  [7:0] reg_wdata = 8'h00;
   reg        reg_wr = 1'b0;
   reg        reg_rd = 1'b0;
   reg        hw_standby = 1'b0;
   reg  [7:0] pwm_outputs = 8'h00;
   reg  [7:0] pwm_en = 8'h00;
   reg        b1_float = 1'b0;
   reg        b2_fight = 1'b0;
   wire [7:0] reg_rdata, p1_in, p1_out, p1_oe, p1_pu, p2_in, p2_out, p2_oe, p2_pu;
   integer    mismatches = 0;
   integer    compares = 0;

   always #10 sys_clk = ~sys_clk;

   dpg_top uut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hw_standby(hw_standby),
      .pwm_outputs(pwm_outputs), .pwm_channel_output_enable(pwm_en),
      .first_port_pins_in(p1_in), .first_port_pins_out(p1_out), .first_port_pins_oe(p1_oe),
      .first_port_pullup_on(p1_pu), .second_port_pins_in(p2_in),
      .second_port_pins_out(p2_out), .second_port_pins_oe(p2_oe),
      .second_port_pullup_on(p2_pu));
   dpg_board u_b1 (.sys_clk(sys_clk), .pin_out(p1_out), .pin_oe(p1_oe), .pull_on(p1_pu),
      .ext_val(8'h3c), .ext_float(b1_float), .fight(1'b0), .pin_in(p1_in));
   dpg_board u_b2 (.sys_clk(sys_clk), .pin_out(p2_out), .pin_oe(p2_oe), .pull_on(p2_pu),
      .ext_val(8'hc3), .ext_float(1'b0), .fight(b2_fight), .pin_in(p2_in));
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input [7:0] got, input [7:0] exp);
   begin
      compares = compares + 1;
      if (got !== exp)
      begin
         mismatches = mismatches + 1;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask
   // Strobe left high so writes may run back to back
   task wr(input [3:0] a, input [7:0] d);
   begin
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
   end
   endtask
   task idle;
   begin
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
   end
   endtask
   task wt(input integer n);
   begin
      repeat (n) @(posedge sys_clk);
      #1;
   end
   endtask
   // Read data stands only in the cycle after the strobe
   task rd(input [3:0] a, input [7:0] exp);
   begin
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task t_reset;
   begin
      chk(p1_oe | p2_oe | p1_pu | p2_pu, 8'h00);
      rd(4'h0, 8'h00);
      rd(4'h1, 8'h3c);
      rd(4'h4, 8'hc3);
      rd(4'h5, 8'h00);
      wr(4'h9, 8'hff);
      rd(4'h9, 8'h00);
      rd(4'h2, 8'h00);
      $display("test reset done");
   end
   endtask
   task t_port1;
   begin
      wr(4'h1, 8'h00);
      wr(4'h1, 8'ha5);
      rd(4'h1, 8'h3c);
      wr(4'h0, 8'h0f);
      idle;
      wt(2);
      chk(p1_oe, 8'h0f);
      chk(p1_out & 8'h0f, 8'h05);
      rd(4'h1, 8'h35);
      $display("test port1 done");
   end
   endtask
   task t_port2;
   begin
      b2_fight <= 1'b1;
      wr(4'h4, 8'h5a);
      wr(4'h3, 8'hf0);
      idle;
      wt(3);
      chk(p2_oe, 8'hf0);
      chk(p2_out & 8'hf0, 8'h50);
      rd(4'h4, 8'h53);
      $display("test port2 done");
   end
   endtask
   task t_pull;
   begin
      wr(4'h2, 8'hff);
      wr(4'h5, 8'h0f);
      idle;
      wt(2);
      chk(p1_pu, 8'hf0);
      chk(p2_pu, 8'h0f);
      rd(4'h2, 8'hff);
      b1_float <= 1'b1;
      wt(3);
      rd(4'h1, 8'hf5);
      @(posedge sys_clk);
      hw_standby <= 1'b1;
      wt(4);
      chk(p1_pu | p2_pu, 8'h00);
      @(posedge sys_clk);
      hw_standby <= 1'b0;
      wt(4);
      chk(p1_pu, 8'hf0);
      b1_float <= 1'b0;
      $display("test pull done");
   end
   endtask
   task t_pwm;
   begin
      @(posedge sys_clk);
      pwm_outputs <= 8'h96;
      pwm_en <= 8'hff;
      wt(2);
      chk(p1_out, 8'ha6);
      chk(p1_oe, 8'h0f);
      @(posedge sys_clk);
      pwm_en <= 8'h00;
      wt(2);
      chk(p1_out, 8'ha5);
      $display("test pwm done");
   end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task summarize;
   begin
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   end
   endtask
   // Watchdog: whole run is well under two thousand cycles
   initial
   begin
      #100000;
      mismatches = mismatches + 1;
      summarize;
   end
   initial
   begin
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      wt(2);
      t_reset;
      t_port1;
      t_port2;
      t_pull;
      t_pwm;
      summarize;
   end
endmodule
